// ==== esq_exposure_seq.sv ====
// Purpose: exposure control, hdr sequencing and frame info block insertion
// Assumes: frame_start and integ_end are one-cycle pulses on ref_clk_in
// Notes: registers over AXI4-Lite; pixel path runs at most one beat per two cycles
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module esq_exposure_seq #(
  parameter int ADDR_W = 16,
  parameter int TICK_CYCLES = esq_pkg::TICK_CYCLES,
  parameter logic [31:0] SERIAL_NUM = 32'h0000_5a17 // arbitrary value
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [ADDR_W-1:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  input wire logic frame_start_in,
  input wire logic integ_end_in,
  input wire logic pix_valid_in,
  input wire esq_pkg::esq_pix_s pix_in,
  output logic pix_ready_out,
  output logic out_valid_out,
  output esq_pkg::esq_pix_s out_data_out,
  input wire logic out_ready_in,
  output esq_pkg::esq_exp_s sens_shut_out [esq_pkg::N_SENS],
  output esq_pkg::esq_exp_s sens_gain_out [esq_pkg::N_SENS],
  output logic [esq_pkg::N_SENS-1:0] sens_ae_out,
  output logic [31:0] img_bright_out,
  output logic [31:0] img_wb_out,
  output logic [31:0] img_gamma_out
);
  import esq_pkg::*;
  localparam int WCNT_W = $clog2(HDR_WORDS + 1);
  localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(HDR_WORDS - 1);

  typedef enum logic [1:0] {S_WAIT, S_HDR, S_PEND, S_PASS} esq_st_e;

  function automatic esq_dec_s decode(input logic [15:0] a);
    esq_dec_s d;
    d = '{1'b1, G_NONE, a[4:2]};
    if (a[15:2] == OFS_SHUT[15:2]) d.grp = G_SHUT;
    else if (a[15:2] == OFS_GAIN[15:2]) d.grp = G_GAIN;
    else if (a[15:2] == OFS_INQ[15:2]) d.grp = G_INQ;
    else if (a[15:2] == OFS_TS[15:2]) d.grp = G_TS;
    else if (a[15:5] == OFS_SUB_SHUT[15:5] && a[4:2] < 3'(N_SENS)) d.grp = G_SSH;
    else if (a[15:5] == OFS_SUB_GAIN[15:5] && a[4:2] < 3'(N_SENS)) d.grp = G_SGA;
    else if (a[15:4] == OFS_PAIR[15:4]) d.grp = G_PAIR;
    else if (a[15:5] == OFS_IMG[15:5] && a[4:2] < 3'(N_IMG)) d.grp = G_IMG;
    else if (a[15:2] == OFS_HDR[15:2]) d.grp = G_HDR;
    else d.hit = 1'b0;
    return d;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // control and configuration registers
  logic [31:0] shut_q;
  logic [31:0] gain_q;
  logic [31:0] sub_shut_q [N_SENS];
  logic [31:0] sub_gain_q [N_SENS];
  logic [31:0] pair_q [N_PAIR];
  logic [31:0] img_q [N_IMG];
  logic hdr_en_q;
  logic hdr_act_q;
  logic [1:0] hdr_idx_q;
  logic [31:0] seq_q;
  logic [31:0] snap_q [HDR_WORDS];
  logic [31:0] ts_w;

  // bus slave state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // stream state
  esq_st_e st_q;
  logic [WCNT_W-1:0] wcnt_q;
  esq_pix_s pend_q;
  esq_pix_s out_q;
  logic ovalid_q;
  logic pready_q;

  wire esq_dec_s wdec = decode(16'(awaddr_q));
  wire esq_dec_s rdec = decode(16'(axi_araddr_in));
  wire wr_go = !awready_q && !wready_q && !bvalid_q;
  wire rd_take = axi_arvalid_in && arready_q;
  wire slot_free = !ovalid_q || out_ready_in;
  wire take = pready_q && pix_valid_in;
  wire [31:0] hdr_stat = {23'h0, hdr_act_q, 2'h0, hdr_idx_q, 3'h0, hdr_en_q};
  logic [31:0] rd_data;

  esq_timestamp #(.TICK_CYCLES(TICK_CYCLES)) u_ts (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ts_out(ts_w)
  );

  for (genvar g = 0; g < N_SENS; g++) begin : g_sens
    esq_sensor_sel u_sel (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .glob_shut_in(shut_q),
      .glob_gain_in(gain_q),
      .sub_shut_in(sub_shut_q[g]),
      .sub_gain_in(sub_gain_q[g]),
      .hdr_on_in(hdr_act_q),
      .hdr_pair_in(pair_q[hdr_idx_q]),
      .shut_out(sens_shut_out[g]),
      .gain_out(sens_gain_out[g]),
      .ae_out(sens_ae_out[g])
    );
  end

  always_comb begin
    case (rdec.grp)
      G_SHUT: rd_data = shut_q;
      G_GAIN: rd_data = gain_q;
      G_INQ: rd_data = INQ_VALUE;
      G_TS: rd_data = ts_w;
      G_SSH: rd_data = sub_shut_q[rdec.idx];
      G_SGA: rd_data = sub_gain_q[rdec.idx];
      G_PAIR: rd_data = pair_q[rdec.idx[1:0]];
      G_IMG: rd_data = img_q[rdec.idx];
      G_HDR: rd_data = hdr_stat;
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (axi_awvalid_in && awready_q) begin
        awaddr_q <= axi_awaddr_in;
        awready_q <= 1'b0;
      end
      if (axi_wvalid_in && wready_q) begin
        wdata_q <= axi_wdata_in;
        wstrb_q <= axi_wstrb_in;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
      end
      // both channels stay closed until the response is taken
      if (bvalid_q && axi_bready_in) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axi_rready_in) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shut_q <= SHUT_RST;
      gain_q <= GAIN_RST;
      hdr_en_q <= 1'b0;
      for (int i = 0; i < N_SENS; i++) begin
        sub_shut_q[i] <= '0;
        sub_gain_q[i] <= '0;
      end
      for (int i = 0; i < N_PAIR; i++) pair_q[i] <= '0;
      for (int i = 0; i < N_IMG; i++) img_q[i] <= '0;
    end else if (wr_go && wdec.hit) begin
      case (wdec.grp)
        G_SHUT: shut_q <= merge(shut_q, wdata_q, wstrb_q);
        G_GAIN: gain_q <= merge(gain_q, wdata_q, wstrb_q);
        G_SSH: sub_shut_q[wdec.idx] <= merge(sub_shut_q[wdec.idx], wdata_q, wstrb_q);
        G_SGA: sub_gain_q[wdec.idx] <= merge(sub_gain_q[wdec.idx], wdata_q, wstrb_q);
        G_PAIR: pair_q[wdec.idx[1:0]] <= merge(pair_q[wdec.idx[1:0]], wdata_q, wstrb_q);
        G_IMG: img_q[wdec.idx] <= merge(img_q[wdec.idx], wdata_q, wstrb_q);
        G_HDR: if (wstrb_q[0]) hdr_en_q <= wdata_q[HDR_EN_BIT];
        default: hdr_en_q <= hdr_en_q;
      endcase
    end
  end

  // hdr steps only on frame boundaries so a frame never mixes two pairs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hdr_act_q <= 1'b0;
      hdr_idx_q <= 2'h0;
    end else if (frame_start_in) begin
      if (!hdr_en_q) begin
        hdr_act_q <= 1'b0;
      end else if (!hdr_act_q) begin
        hdr_act_q <= 1'b1;
        hdr_idx_q <= 2'h0;
      end else begin
        hdr_idx_q <= hdr_idx_q + 2'h1;
      end
    end
  end

  // info block contents, captured together at end of integration
  logic [31:0] info_w [HDR_WORDS];
  assign info_w[0] = ts_w;
  assign info_w[1] = seq_q;
  assign info_w[2] = img_q[IMG_HRATE];
  for (genvar g = 0; g < N_SENS; g++) begin : g_info
    assign info_w[3 + g] = {3'h0, sens_gain_out[g], 3'h0, sens_shut_out[g]};
  end
  assign info_w[9] = img_q[IMG_BRIGHT];
  assign info_w[10] = img_q[IMG_WB];
  assign info_w[11] = img_q[IMG_GAMMA];
  assign info_w[12] = img_q[IMG_BGAIN];
  assign info_w[13] = img_q[IMG_BMAP];
  assign info_w[14] = SERIAL_NUM;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_q <= '0;
      for (int i = 0; i < HDR_WORDS; i++) snap_q[i] <= '0;
    end else if (integ_end_in) begin
      seq_q <= seq_q + 32'h1;
      for (int i = 0; i < HDR_WORDS; i++) snap_q[i] <= info_w[i];
    end
  end

  // pixel data passes through unaltered behind the info block; any hdr merging is left to the host
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= S_WAIT;
      wcnt_q <= '0;
      pend_q <= '0;
      out_q <= '0;
      ovalid_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      if (ovalid_q && out_ready_in) ovalid_q <= 1'b0;
      case (st_q)
        S_WAIT: begin
          if (!pready_q) pready_q <= 1'b1;
          else if (take && pix_in.sof) begin
            pend_q <= pix_in;
            pready_q <= 1'b0;
            wcnt_q <= '0;
            st_q <= S_HDR;
          end
        end
        S_HDR: if (slot_free) begin
          out_q <= '{(wcnt_q == '0), 1'b0, snap_q[wcnt_q]};
          ovalid_q <= 1'b1;
          wcnt_q <= wcnt_q + 1'b1;
          if (wcnt_q == WCNT_LAST) st_q <= S_PEND;
        end
        S_PEND: if (slot_free) begin
          out_q <= '{1'b0, pend_q.eof, pend_q.data};
          ovalid_q <= 1'b1;
          st_q <= pend_q.eof ? S_WAIT : S_PASS;
        end
        S_PASS: begin
          if (take) begin
            out_q <= '{1'b0, pix_in.eof, pix_in.data};
            ovalid_q <= 1'b1;
            pready_q <= 1'b0;
            if (pix_in.eof) st_q <= S_WAIT;
          end else if (!pready_q && slot_free) begin
            pready_q <= 1'b1;
          end
        end
        default: st_q <= S_WAIT;
      endcase
    end
  end

  assign axi_awready_out = awready_q;
  assign axi_wready_out = wready_q;
  assign axi_bvalid_out = bvalid_q;
  assign axi_bresp_out = bresp_q;
  assign axi_arready_out = arready_q;
  assign axi_rvalid_out = rvalid_q;
  assign axi_rdata_out = rdata_q;
  assign axi_rresp_out = rresp_q;
  assign pix_ready_out = pready_q;
  assign out_valid_out = ovalid_q;
  assign out_data_out = out_q;
  assign img_bright_out = img_q[IMG_BRIGHT];
  assign img_wb_out = img_q[IMG_WB];
  assign img_gamma_out = img_q[IMG_GAMMA];

  sequence s_first_word;
    ovalid_q && out_q.sof && out_ready_in;
  endsequence
  sequence s_hdr_step;
    frame_start_in && hdr_en_q && hdr_act_q;
  endsequence

  chk_info_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_first_word |-> (st_q == S_HDR || st_q == S_PEND) && out_q.data == snap_q[0])
    else $error("frame did not open with its info block");
  chk_hdr_step: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_hdr_step |=> (hdr_idx_q == $past(hdr_idx_q) + 2'h1) && hdr_act_q)
    else $error("hdr pair did not advance");
  chk_hdr_begin: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (frame_start_in && hdr_en_q && !hdr_act_q) |=> hdr_act_q && hdr_idx_q == 2'h0)
    else $error("hdr did not start at pair one");
  chk_hdr_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (frame_start_in && !hdr_en_q) |=> !hdr_act_q ##1 (!sens_shut_out[0].auto_en || !hdr_act_q))
    else $error("hdr did not stop at frame start");
  chk_snap_time: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    integ_end_in |=> snap_q[0] == $past(ts_w) && snap_q[1] == $past(seq_q))
    else $error("info block not latched at integration end");
  chk_ts_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && rdec.grp == G_TS) |=> rvalid_q && rdata_q == $past(ts_w))
    else $error("timestamp register read wrong");
  chk_hdr_len: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_q == S_HDR && slot_free && wcnt_q == WCNT_LAST) |=> st_q == S_PEND)
    else $error("info block length wrong");
endmodule

// ==== esq_pkg.sv ====
// Purpose: shared constants and types for the exposure sequencer and frame metadata block
// Assumes: one 250 MHz clock, AXI4-Lite register access, six sensors
package esq_pkg;
  localparam int N_SENS = 6;
  localparam int N_PAIR = 4;
  localparam int N_IMG = 6;
  localparam int VAL_W = 12;
  localparam int HDR_WORDS = 15;

  localparam logic [15:0] OFS_SHUT = 16'h081c;
  localparam logic [15:0] OFS_GAIN = 16'h0820;
  localparam logic [15:0] OFS_INQ = 16'h1e94;
  localparam logic [15:0] OFS_TS = 16'h1ea8;
  localparam logic [15:0] OFS_SUB_SHUT = 16'h0900;
  localparam logic [15:0] OFS_SUB_GAIN = 16'h0920;
  localparam logic [15:0] OFS_PAIR = 16'h0940;
  localparam logic [15:0] OFS_IMG = 16'h0960;
  localparam logic [15:0] OFS_HDR = 16'h0980;

  // control register fields
  localparam int BIT_GLOBAL = 24;
  localparam int BIT_AUTO = 25;
  localparam int BIT_AE = 26;
  localparam int PAIR_GAIN_LSB = 16;
  localparam int HDR_EN_BIT = 0;
  localparam int HDR_IDX_LSB = 4;
  localparam int HDR_ACT_BIT = 8;
  // common image settings slots
  localparam int IMG_BRIGHT = 0;
  localparam int IMG_WB = 1;
  localparam int IMG_GAMMA = 2;
  localparam int IMG_BGAIN = 3;
  localparam int IMG_BMAP = 4;
  localparam int IMG_HRATE = 5;

  localparam logic [31:0] SHUT_RST = 32'h0300_0100;
  localparam logic [31:0] GAIN_RST = 32'h0300_0000;
  localparam logic [31:0] INQ_VALUE = 32'h8000_0007;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timestamp: 125 us per cycle count tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 125000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int CYC_W = 13;
  localparam int SEC_W = 7;
  localparam int OFS_W = 12;
  localparam int OFS_SHIFT = 3;
  localparam logic [CYC_W-1:0] CYC_MAX = 13'h1f3f;
  localparam logic [SEC_W-1:0] SEC_MAX = 7'h7f;

  typedef struct packed {
    logic auto_en;
    logic [VAL_W-1:0] value;
  } esq_exp_s;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [31:0] data;
  } esq_pix_s;

  typedef enum logic [3:0] {
    G_NONE, G_SHUT, G_GAIN, G_INQ, G_TS, G_SSH, G_SGA, G_PAIR, G_IMG, G_HDR
  } esq_grp_e;

  typedef struct packed {
    logic hit;
    esq_grp_e grp;
    logic [2:0] idx;
  } esq_dec_s;
endpackage

// ==== esq_timestamp.sv ====
// Purpose: free-running cycle and seconds counters for frame timestamps
// Assumes: single clock, divider gives one tick per cycle count
// Notes: sub-tick offset is a coarse view of the divider
`timescale 1ns/1ns
module esq_timestamp #(
  parameter int TICK_CYCLES = esq_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  output logic [31:0] ts_out
);
  import esq_pkg::*;
  localparam int DIV_W = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  logic [DIV_W-1:0] div_q;
  logic [CYC_W-1:0] cyc_q;
  logic [SEC_W-1:0] sec_q;
  wire tick = (div_q == DIV_LAST);
  wire cyc_wrap = tick && (cyc_q == CYC_MAX);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= '0;
      cyc_q <= '0;
      sec_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) begin
        cyc_q <= cyc_wrap ? '0 : cyc_q + 1'b1;
      end
      if (cyc_wrap) begin
        sec_q <= (sec_q == SEC_MAX) ? '0 : sec_q + 1'b1;
      end
    end
  end

  // low bits are only coarse sub-tick position
  assign ts_out = {sec_q, cyc_q, OFS_W'(div_q >> OFS_SHIFT)};

  chk_cycle_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cyc_wrap |=> (cyc_q == '0) && (sec_q != $past(sec_q)))
    else $error("cycle count did not wrap into seconds");
  chk_sec_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cyc_wrap && sec_q == SEC_MAX) |=> (sec_q == '0))
    else $error("seconds count did not wrap to zero");
endmodule

// ==== esq_sensor_sel.sv ====
// Purpose: resolve the exposure actually applied to one sensor
// Assumes: control words already held in registers of the parent
// Notes: hdr pair overrides both global and per-sensor values
`timescale 1ns/1ns
module esq_sensor_sel (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [31:0] glob_shut_in,
  input wire logic [31:0] glob_gain_in,
  input wire logic [31:0] sub_shut_in,
  input wire logic [31:0] sub_gain_in,
  input wire logic hdr_on_in,
  input wire logic [31:0] hdr_pair_in,
  output esq_pkg::esq_exp_s shut_out,
  output esq_pkg::esq_exp_s gain_out,
  output logic ae_out
);
  import esq_pkg::*;
  wire glob_s = glob_shut_in[BIT_GLOBAL];
  wire glob_g = glob_gain_in[BIT_GLOBAL];
  // hdr pairs are fixed manual values
  wire esq_exp_s pair_s = '{1'b0, hdr_pair_in[VAL_W-1:0]};
  wire esq_exp_s pair_g = '{1'b0, hdr_pair_in[PAIR_GAIN_LSB +: VAL_W]};
  wire esq_exp_s com_s = '{glob_shut_in[BIT_AUTO], glob_shut_in[VAL_W-1:0]};
  wire esq_exp_s com_g = '{glob_gain_in[BIT_AUTO], glob_gain_in[VAL_W-1:0]};
  wire esq_exp_s own_s = '{sub_shut_in[BIT_AUTO], sub_shut_in[VAL_W-1:0]};
  wire esq_exp_s own_g = '{sub_gain_in[BIT_AUTO], sub_gain_in[VAL_W-1:0]};
  wire esq_exp_s shut_d = hdr_on_in ? pair_s : (glob_s ? com_s : own_s);
  wire esq_exp_s gain_d = hdr_on_in ? pair_g : (glob_g ? com_g : own_g);
  wire ae_d = (!glob_s || !glob_g) ? sub_shut_in[BIT_AE] : glob_shut_in[BIT_AE];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shut_out <= '0;
      gain_out <= '0;
      ae_out <= 1'b0;
    end else begin
      shut_out <= shut_d;
      gain_out <= gain_d;
      ae_out <= ae_d;
    end
  end

  chk_shut_global: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (glob_s && !hdr_on_in) |=> (shut_out == $past(com_s)))
    else $error("global shutter not applied");
  chk_gain_own: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!glob_g && !hdr_on_in) |=> (gain_out.value == $past(sub_gain_in[VAL_W-1:0])))
    else $error("per-sensor gain not applied");
  chk_ae_own: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!glob_s || !glob_g) |=> (ae_out == $past(sub_shut_in[BIT_AE])))
    else $error("per-sensor exposure not honoured");
  chk_hdr_pair: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hdr_on_in |=> (!shut_out.auto_en && gain_out == $past(pair_g)))
    else $error("hdr pair not applied");
endmodule

// ==== esq_host_sink.sv ====
// Purpose: host capture side, sink of the framed output stream
// Assumes: one clock shared with the block, a single frame per run
// Notes: stalls one beat in four so the block meets backpressure
`timescale 1ns/1ns
module esq_host_sink (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire esq_pkg::esq_pix_s data_in,
  output logic ready_out
);
  import esq_pkg::*;
  logic [1:0] ph_q;
  esq_pix_s words [64];
  int n = 0;
  assign ready_out = ph_q != 2'h3;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // low timestamp bits are untrustworthy, so they are dropped here
  always @(posedge ref_clk_in) begin
    if (valid_in && ready_out && n < 64) begin
      words[n] <= data_in;
      if (n == 0) begin
        words[0].data[3:0] <= 4'h0;
      end
      n <= n + 1;
    end
  end
endmodule

// ==== exposure_sequencer_frame_metadata_tb_top.sv ====
// Purpose: self-checking bench for the exposure sequencer
// Assumes: short timestamp tick so one second passes within the run
// Notes: handshakes sampled at the falling edge, where they are settled
`timescale 1ns/1ns
module exposure_sequencer_frame_metadata_tb_top;
  import esq_pkg::*;
  localparam logic [31:0] SER = 32'h0000_3c21; // arbitrary value
  logic clk = 0;
  logic rst = 1;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fs = 0, ie = 0, pv = 0;
  logic awr, wrdy, bv, arr, rv, pr, ov, ordy;
  logic [15:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d, ib, iw, ig;
  logic [1:0] br, rr, resp;
  esq_pix_s pin = '0;
  esq_pix_s od;
  esq_exp_s sh [N_SENS];
  esq_exp_s gn [N_SENS];
  logic [5:0] ae;
  int n_fail = 0, n_tests = 0, cyc = 0;
  esq_exposure_seq #(.TICK_CYCLES(8), .SERIAL_NUM(SER)) dut (.ref_clk_in(clk), .rst_in(rst),
    .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa), .axi_wvalid_in(wv),
    .axi_wready_out(wrdy), .axi_wdata_in(wd), .axi_wstrb_in(4'hf), .axi_bvalid_out(bv),
    .axi_bready_in(bre), .axi_bresp_out(br), .axi_arvalid_in(arv), .axi_arready_out(arr),
    .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rre), .axi_rdata_out(rdat),
    .axi_rresp_out(rr), .frame_start_in(fs), .integ_end_in(ie), .pix_valid_in(pv),
    .pix_in(pin), .pix_ready_out(pr), .out_valid_out(ov), .out_data_out(od),
    .out_ready_in(ordy), .sens_shut_out(sh), .sens_gain_out(gn), .sens_ae_out(ae),
    .img_bright_out(ib), .img_wb_out(iw), .img_gamma_out(ig));
  esq_host_sink host (.ref_clk_in(clk), .rst_in(rst), .valid_in(ov), .data_in(od),
    .ready_out(ordy));
  initial forever #2 clk = ~clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done, mismatches %0d", s, n_fail);
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wreg(input logic [15:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= v;
    bre <= 1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv && bre;
      resp = br;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb);
    bre <= 0;
  endtask
  task automatic rreg(input logic [15:0] a);
    logic ta, t;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      t = rv && rre;
      d = rdat;
      resp = rr;
      @(posedge clk);
      if (ta) arv <= 0;
    end while (!t);
    rre <= 0;
  endtask
  task automatic px(input logic s, input logic e, input logic [31:0] v);
    logic t;
    @(posedge clk);
    pv <= 1;
    pin <= '{s, e, v};
    do begin
      @(negedge clk);
      t = pv && pr;
      @(posedge clk);
    end while (!t);
    pv <= 0;
  endtask
  task automatic pulse(input logic f);
    @(posedge clk);
    fs <= f;
    ie <= !f;
    @(posedge clk);
    fs <= 0;
    ie <= 0;
  endtask
  initial begin
    cy(5);
    rst <= 0;
    rreg(OFS_SHUT);
    ck(d, SHUT_RST);
    rreg(OFS_INQ);
    ck(d, INQ_VALUE);
    rreg(16'h0100);
    ck({d[31:2], resp}, {30'h0, RESP_SLVERR});
    wreg(16'h0100, 32'h0000_0001);
    ck(32'(resp), 32'(RESP_SLVERR));
    for (int i = 0; i < N_SENS; i++) begin
      ck(32'(sh[i]), 32'h1100);
      ck(32'(gn[i]), 32'h1000);
    end
    endt("reset");
    wreg(OFS_IMG, 32'h0000_00ab);
    ck(32'(resp), 32'(RESP_OKAY));
    wreg(OFS_IMG + 16'(4 * IMG_WB), 32'h0000_00cd);
    wreg(OFS_IMG + 16'(4 * IMG_GAMMA), 32'h0000_00ef);
    cy(2);
    ck(ib, 32'h0000_00ab);
    ck(iw, 32'h0000_00cd);
    ck(ig, 32'h0000_00ef);
    pulse(0);
    // changed after the snapshot, so the block must still show the old value
    wreg(OFS_SHUT, 32'h0300_0155);
    px(1, 0, 32'h1111_0000);
    px(0, 1, 32'h2222_0000);
    for (int k = 0; k < 200 && host.n < 17; k++) @(posedge clk);
    ck(32'(host.n), 32'd17);
    ck({host.words[0].sof, host.words[16].eof}, 32'h3);
    ck(host.words[1].data, 32'h0);
    ck(host.words[3].data, 32'h1000_1100);
    ck(host.words[9].data, 32'h0000_00ab);
    ck(host.words[10].data, 32'h0000_00cd);
    ck(host.words[11].data, 32'h0000_00ef);
    ck(host.words[14].data, SER);
    ck(host.words[15].data, 32'h1111_0000);
    ck(host.words[16].data, 32'h2222_0000);
    endt("frame");
    for (int k = 0; k < N_PAIR; k++) begin
      wreg(OFS_PAIR + 16'(4 * k), 32'h0020_0010 + 32'(k) * 32'h0001_0001);
    end
    wreg(OFS_HDR, 32'h1);
    cy(2);
    ck(32'(sh[3]), 32'h1155);
    for (int j = 0; j < 6; j++) begin
      pulse(1);
      cy(2);
      ck(32'(sh[3]), 32'h10 + 32'(j % 4));
      ck(32'(gn[3]), 32'h20 + 32'(j % 4));
    end
    rreg(OFS_HDR);
    ck(d, 32'h0000_0111);
    rreg(OFS_PAIR + 16'h0004);
    ck(d, 32'h0021_0011);
    wreg(OFS_HDR, 32'h0);
    pulse(1);
    cy(2);
    ck(32'(sh[3]), 32'h1155);
    endt("hdr");
    for (int i = 0; i < N_SENS; i++) begin
      wreg(OFS_SUB_SHUT + 16'(4 * i), (i == 2 ? 32'h0400_0000 : 32'h0) + 32'h200 + 32'(i));
      wreg(OFS_SUB_GAIN + 16'(4 * i), 32'h300 + 32'(i));
    end
    cy(2);
    ck(32'(sh[5]), 32'h1155);
    ck(32'(gn[5]), 32'h1000);
    ck(32'(ae), 32'h0);
    wreg(OFS_SHUT, 32'h0200_0155);
    cy(2);
    for (int i = 0; i < N_SENS; i++) begin
      ck(32'(sh[i]), 32'h200 + 32'(i));
      ck(32'(gn[i]), 32'h1000);
    end
    ck(32'(ae), 32'h4);
    wreg(OFS_GAIN, 32'h0200_0000);
    cy(2);
    for (int i = 0; i < N_SENS; i++) begin
      ck(32'(gn[i]), 32'h300 + 32'(i));
    end
    endt("per_sensor");
    while (cyc < 64100) @(posedge clk);
    rreg(OFS_TS);
    ck({25'h0, d[31:25]}, 32'h1);
    ck(32'(d[24:12] < 13'd100), 32'h1);
    endt("timestamp");
    close_out;
  end
endmodule
